// ===== shc_pkg.sv
// Purpose: Shared constants and carrier types for the speech codec homing control.
// Assumes: Samples are 16-bit left-justified words; decoder parameters arrive one bit per beat.
// Notes: Per-mode homing patterns and field lengths are supplied from outside at configuration time.
`default_nettype none
package shc_pkg;
    // Codec modes and pattern store geometry
    localparam int unsigned NUM_MODES = 8;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned BIT_IDX_W = 8;
    localparam int unsigned PAT_ADDR_W = MODE_W + BIT_IDX_W;
    localparam int unsigned PAT_DEPTH = 1 << PAT_ADDR_W;
    // Speech sample framing
    localparam int unsigned SMP_W = 16;
    localparam int unsigned SMP_CNT_W = 8;
    localparam logic [SMP_CNT_W-1:0] SAMPLES_PER_FRAME = 8'ha0;
    // Encoder homing sample: 13-bit one, left justified in 16 bits
    localparam logic [SMP_W-1:0] EHF_SAMPLE = 16'h0008;
    // Reset values of the home flags: a freshly reset codec is in home state
    localparam logic HOME_RST = 1'b1;

    // Codec configuration, fixed by external means at reset
    typedef struct packed {
        logic [MODE_W-1:0] mode;              // Codec mode in use
        logic [BIT_IDX_W-1:0] frame_bits;     // Parameter bits per frame for that mode
        logic [BIT_IDX_W-1:0] early_bits;     // Bits of prediction plus first subframe
    } shc_cfg_t;

    // Pattern store write port
    typedef struct packed {
        logic wr;
        logic [PAT_ADDR_W-1:0] addr;
        logic data;
    } shc_pat_wr_t;

    // Homing status reported to the codec cores
    typedef struct packed {
        logic enc_in_home;     // Encoder is in home state
        logic enc_homing;      // Last complete input frame was an encoder homing frame
        logic enc_expect_dhf;  // Its output must equal the decoder homing frame
        logic dec_in_home;     // Decoder is in home state
        logic dec_homing;      // Last complete parameter frame was a decoder homing frame
    } shc_status_t;
endpackage : shc_pkg
`default_nettype wire

// ===== shc_pattern_mem.sv
// Purpose: One-bit-wide store of the decoder homing patterns, one region per codec mode.
// Assumes: Loaded before bit-exact traffic starts; read data is registered.
// Notes: A write and a read to the same address in one cycle return the old bit.
`timescale 1ns/1ps
`default_nettype none
module shc_pattern_mem (
    // Clock
    input wire logic core_clk_i,
    // Write port
    input wire logic wr_i,
    input wire logic [shc_pkg::PAT_ADDR_W-1:0] wr_addr_i,
    input wire logic wr_data_i,
    // Read port
    input wire logic [shc_pkg::PAT_ADDR_W-1:0] rd_addr_i,
    output logic rd_data_o
);
    // Storage array, no reset: contents come from the load port
    logic mem_q [shc_pkg::PAT_DEPTH];

    // Write side
    always_ff @(posedge core_clk_i) begin
        if (wr_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read
    always_ff @(posedge core_clk_i) begin
        rd_data_o <= mem_q[rd_addr_i];
    end
endmodule : shc_pattern_mem
`default_nettype wire

// ===== shc_homing_ctrl.sv
// Purpose: Detects in-band homing frames on both codec directions and pulses the state resets.
// Assumes: One frame in flight per direction; the encoder core reports end of output, decoder output end is counted from dec_smp_valid_i.
// Notes: Samples and parameter bits are taken as synchronous to core_clk_i.
// How it works
// (R01) Eight decoder patterns, chosen by configured mode
// (R02) Encoder homing only on own frame boundaries
// (R03) Home encoder output must equal decoder pattern
// (R04) Encoder reset after homing frame output done
// (R05) Only configured-mode pattern triggers decoder homing
// (R06) Home decoder output replaced by encoder frame
// (R07) Decoder reset after homing frame output done
// (R08) Test sequences differ early from homing frame
// (R09) Home decoder may detect homing frame early
// (R10) Encoder frame is 160 samples of 0008
// (R11) Mode configured by controller before testing
// (R12) Compare whole frame, latch, reset afterwards
`timescale 1ns/1ps
`default_nettype none
module shc_homing_ctrl (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Configuration and pattern load
    input wire shc_pkg::shc_cfg_t cfg_i,
    input wire shc_pkg::shc_pat_wr_t pat_wr_i,
    // Encoder input samples and core completion
    input wire logic enc_smp_valid_i,
    input wire logic [shc_pkg::SMP_W-1:0] enc_smp_i,
    input wire logic enc_frame_done_i,
    // Decoder parameter bits
    input wire logic dec_bit_valid_i,
    input wire logic dec_bit_i,
    // Decoder core output samples
    input wire logic dec_smp_valid_i,
    input wire logic [shc_pkg::SMP_W-1:0] dec_smp_i,
    // Decoder output samples after substitution
    output logic dec_out_valid_o,
    output logic [shc_pkg::SMP_W-1:0] dec_out_smp_o,
    // Homing events and status
    output logic enc_home_reset_o,
    output logic dec_home_reset_o,
    output logic dec_early_hit_o,
    output shc_pkg::shc_status_t status_o
);
    // True on the last index of a frame of the given length
    function automatic logic is_last(input logic [7:0] cnt, input logic [7:0] len);
        is_last = (cnt == len - 8'h01);
    endfunction : is_last

    // ---------------- Encoder side ----------------
    logic [shc_pkg::SMP_CNT_W-1:0] enc_cnt_q, enc_cnt_d; // Own frame segmentation
    logic enc_run_q, enc_run_d;       // All samples so far were homing samples
    logic enc_home_q;                 // Encoder in home state
    logic enc_start_home_q;           // Home state sampled at frame start
    logic enc_pend_q;                 // Latched homing decision awaiting core output
    logic enc_expect_q;               // Output must be the decoder homing frame
    logic enc_rst_q;                  // Reset pulse
    wire enc_first = (enc_cnt_q == '0);
    wire enc_last = is_last(enc_cnt_q, shc_pkg::SAMPLES_PER_FRAME);
    wire enc_smp_hit = (enc_smp_i == shc_pkg::EHF_SAMPLE); // R10
    // Running match restarts at each own frame boundary so misaligned frames never match
    wire enc_acc = (enc_first | enc_run_q) & enc_smp_hit; // R02

    // Next-state for the sample counter and running match
    always_comb begin
        enc_cnt_d = enc_cnt_q;
        enc_run_d = enc_run_q;
        if (enc_smp_valid_i) begin
            enc_cnt_d = enc_last ? '0 : enc_cnt_q + 8'h01;
            enc_run_d = enc_acc;
        end
    end

    // Encoder segmentation and match registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_cnt_q <= '0;
            enc_run_q <= 1'b0;
        end else begin
            enc_cnt_q <= enc_cnt_d;
            enc_run_q <= enc_run_d;
        end
    end

    // Home state at frame start, latched at first sample
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_start_home_q <= shc_pkg::HOME_RST;
        end else if (enc_smp_valid_i && enc_first) begin
            enc_start_home_q <= enc_home_q;
        end
    end

    // Frame decision latched at last sample; core still processes the frame normally
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_pend_q <= 1'b0;
            enc_expect_q <= 1'b0;
        end else if (enc_smp_valid_i && enc_last) begin
            enc_pend_q <= enc_acc; // R12
            enc_expect_q <= enc_acc & enc_start_home_q; // R03
        end
    end

    // Reset applied only once the core has emitted that frame's output
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enc_home_q <= shc_pkg::HOME_RST;
            enc_rst_q <= 1'b0;
        end else begin
            enc_rst_q <= enc_frame_done_i & enc_pend_q; // R04
            if (enc_frame_done_i) begin
                // Any ordinary frame moves the state away from home
                enc_home_q <= enc_pend_q; // R04
            end
        end
    end

    // ---------------- Decoder parameter side ----------------
    logic [shc_pkg::BIT_IDX_W-1:0] bit_cnt_q;  // Parameter bit index
    logic pat_bit;                             // Pattern bit, one cycle after address
    logic cmp_v_q;                             // Compare stage valid
    logic cmp_bit_q;                           // Received bit held for compare
    logic [shc_pkg::BIT_IDX_W-1:0] cmp_idx_q;  // Index of held bit
    logic dec_run_q;                           // Running match
    logic dec_home_q;                          // Decoder in home state
    logic dec_start_home_q;                    // Home state at frame start
    logic dec_pend_q;                          // Latched homing decision
    logic dec_sub_q;                           // Substitute output samples
    logic early_q;                             // Early detection pulse
    logic dec_rst_q;                           // Reset pulse
    // Pattern selected by configured mode only, so other modes' patterns decode normally
    wire [shc_pkg::PAT_ADDR_W-1:0] rd_addr = {cfg_i.mode, bit_cnt_q}; // R01 R05
    wire bit_last = is_last(bit_cnt_q, cfg_i.frame_bits);
    wire cmp_first = (cmp_idx_q == '0);
    wire cmp_last = is_last(cmp_idx_q, cfg_i.frame_bits);
    wire cmp_early = is_last(cmp_idx_q, cfg_i.early_bits);
    wire dec_acc = (cmp_first | dec_run_q) & (cmp_bit_q == pat_bit);
    // Sources keep the first test frame distinct within these bits, so a prefix match suffices
    wire early_hit = cmp_v_q & cmp_early & dec_acc & dec_start_home_q; // R08 R09

    // Pattern store, one region per codec mode
    shc_pattern_mem u_pat_mem (
        .core_clk_i(core_clk_i),
        .wr_i(pat_wr_i.wr),
        .wr_addr_i(pat_wr_i.addr),
        .wr_data_i(pat_wr_i.data),
        .rd_addr_i(rd_addr),
        .rd_data_o(pat_bit)
    );

    // Bit counter and compare pipeline; pattern read has one cycle of latency
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_q <= '0;
            cmp_v_q <= 1'b0;
            cmp_bit_q <= 1'b0;
            cmp_idx_q <= '0;
        end else begin
            cmp_v_q <= dec_bit_valid_i;
            if (dec_bit_valid_i) begin
                bit_cnt_q <= bit_last ? '0 : bit_cnt_q + 8'h01;
                cmp_bit_q <= dec_bit_i;
                cmp_idx_q <= bit_cnt_q;
            end
        end
    end

    // Running match, start-of-frame home state and frame decision
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_run_q <= 1'b0;
            dec_start_home_q <= shc_pkg::HOME_RST;
            dec_pend_q <= 1'b0;
            dec_sub_q <= 1'b0;
            early_q <= 1'b0;
        end else begin
            early_q <= early_hit; // R09
            if (dec_bit_valid_i && bit_cnt_q == '0) begin
                dec_start_home_q <= dec_home_q;
            end
            if (cmp_v_q) begin
                dec_run_q <= dec_acc;
                if (cmp_last) begin
                    dec_pend_q <= dec_acc; // R12 R05
                    dec_sub_q <= dec_acc & dec_start_home_q; // R06
                end
            end
        end
    end

    // ---------------- Decoder output side ----------------
    logic [shc_pkg::SMP_CNT_W-1:0] out_cnt_q; // Output sample index
    wire out_last = is_last(out_cnt_q, shc_pkg::SAMPLES_PER_FRAME);
    // Normal decoding continues; only the emitted samples are replaced
    wire [shc_pkg::SMP_W-1:0] out_smp = dec_sub_q ? shc_pkg::EHF_SAMPLE : dec_smp_i; // R06

    // Output registers and substitution
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_cnt_q <= '0;
            dec_out_valid_o <= 1'b0;
            dec_out_smp_o <= '0;
        end else begin
            dec_out_valid_o <= dec_smp_valid_i;
            if (dec_smp_valid_i) begin
                out_cnt_q <= out_last ? '0 : out_cnt_q + 8'h01;
                dec_out_smp_o <= out_smp;
            end
        end
    end

    // Reset after the last output sample of a homing frame, comfort noise included
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_home_q <= shc_pkg::HOME_RST;
            dec_rst_q <= 1'b0;
        end else begin
            dec_rst_q <= dec_smp_valid_i & out_last & dec_pend_q; // R07
            if (dec_smp_valid_i && out_last) begin
                dec_home_q <= dec_pend_q; // R07
            end
        end
    end

    // Outputs
    assign enc_home_reset_o = enc_rst_q;
    assign dec_home_reset_o = dec_rst_q;
    assign dec_early_hit_o = early_q;
    assign status_o = '{enc_in_home: enc_home_q, enc_homing: enc_pend_q, enc_expect_dhf: enc_expect_q,
                        dec_in_home: dec_home_q, dec_homing: dec_pend_q};
endmodule : shc_homing_ctrl
`default_nettype wire

// ===== shc_homing_ctrl_assertions.sv
// Purpose: Concurrent checks on the homing control ports.
// Assumes: One clock domain; reset low disables every check.
// Notes: Pass-through is checked only where no homing decision stands; substitution itself is not checked.
`timescale 1ns/1ps
`default_nettype none
module shc_homing_ctrl_assertions (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Watched inputs
    input wire logic enc_frame_done_i,
    input wire logic dec_smp_valid_i,
    input wire logic [shc_pkg::SMP_W-1:0] dec_smp_i,
    // Watched outputs
    input wire logic dec_out_valid_o,
    input wire logic [shc_pkg::SMP_W-1:0] dec_out_smp_o,
    input wire logic enc_home_reset_o,
    input wire logic dec_home_reset_o,
    input wire logic dec_early_hit_o,
    input wire shc_pkg::shc_status_t status_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // An event that lasts exactly one cycle
    sequence s_pulse(x);
        x ##1 !x;
    endsequence
    a_enc_rst_pulse: assert property (enc_home_reset_o |-> s_pulse(enc_home_reset_o))
        else $error("encoder reset pulse too long");
    a_enc_rst_cause: assert property (enc_frame_done_i |=> enc_home_reset_o == $past(status_o.enc_homing))
        else $error("encoder reset does not follow homing decision");
    a_enc_home_track: assert property (enc_frame_done_i |=> status_o.enc_in_home == $past(status_o.enc_homing))
        else $error("encoder home flag wrong after frame");
    a_enc_expect_hom: assert property (status_o.enc_expect_dhf |-> status_o.enc_homing)
        else $error("expect flag without homing frame");
    a_dec_out_follow: assert property (dec_smp_valid_i |=> dec_out_valid_o)
        else $error("decoder output strobe missing");
    a_dec_pass_thru: assert property (dec_smp_valid_i && !status_o.dec_homing
        |=> dec_out_smp_o == $past(dec_smp_i))
        else $error("decoder sample altered outside homing");
    a_dec_rst_cause: assert property (dec_home_reset_o |-> status_o.dec_homing && $past(dec_smp_valid_i))
        else $error("decoder reset without homing frame");
    a_early_pulse: assert property (dec_early_hit_o |-> s_pulse(dec_early_hit_o))
        else $error("early hit pulse too long");
    a_early_home: assert property (dec_early_hit_o |-> status_o.dec_in_home)
        else $error("early hit outside home state");
endmodule : shc_homing_ctrl_assertions
bind shc_homing_ctrl shc_homing_ctrl_assertions u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .enc_frame_done_i(enc_frame_done_i), .dec_smp_valid_i(dec_smp_valid_i), .dec_smp_i(dec_smp_i),
    .dec_out_valid_o(dec_out_valid_o), .dec_out_smp_o(dec_out_smp_o), .enc_home_reset_o(enc_home_reset_o),
    .dec_home_reset_o(dec_home_reset_o), .dec_early_hit_o(dec_early_hit_o), .status_o(status_o));
`default_nettype wire

// ===== shc_remote_codec.sv
// Purpose: Remote encoder model sending parameter frames to the decoder input.
// Assumes: Frames of FRAME_BITS bits, driven 1 ns after the rising edge.
// Notes: The data line shows the inverse of its last bit once released.
`timescale 1ns/1ps
`default_nettype none
module shc_remote_codec #(
    parameter int FRAME_BITS = 16
) (
    // Clock
    input wire logic core_clk_i,
    // Parameter bit stream
    output var logic dec_bit_valid_o,
    output var logic dec_bit_o
);
    int seed = 10164; // Own fixed seed
    initial begin
        dec_bit_valid_o = 1'b0;
        dec_bit_o = 1'b0;
    end
    // Homing pattern bit of a mode, distinct per mode
    function automatic logic pb(input int m, input int i);
        int t;
        t = (m * 37 + i * 11) >> 2;
        return t[0];
    endfunction : pb
    // One frame: a mode's homing pattern, or random traffic
    task send(input logic hom, input int m, input int cm);
        for (int i = 0; i < FRAME_BITS; i++) begin
            @(posedge core_clk_i);
            #1;
            dec_bit_valid_o = 1'b1;
            // Random frames differ from the homing frame at the first bit
            dec_bit_o = hom ? pb(m, i) : (i == 0 ? ~pb(cm, 0) : 1'($random(seed)));
        end
        @(posedge core_clk_i);
        #1;
        dec_bit_valid_o = 1'b0;
        dec_bit_o = ~dec_bit_o;
    endtask : send
endmodule : shc_remote_codec
`default_nettype wire

// ===== speech_codec_homing_control_tb.sv
// Purpose: Self-checking bench for the homing control.
// Assumes: Frames of 16 parameter bits, 6 of them early bits.
// Notes: Expected values come from bench-side home tracking.
`timescale 1ns/1ps
`default_nettype none
module speech_codec_homing_control_tb;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    shc_pkg::shc_cfg_t cfg_i = '0;
    shc_pkg::shc_pat_wr_t pat_wr_i = '0;
    logic enc_smp_valid_i = 1'b0;
    logic [15:0] enc_smp_i = 16'h0000;
    logic enc_frame_done_i = 1'b0;
    logic dec_smp_valid_i = 1'b0;
    logic [15:0] dec_smp_i = 16'h0000;
    logic dec_bit_valid_i, dec_bit_i, dec_out_valid_o, enc_home_reset_o, dec_home_reset_o, dec_early_hit_o;
    logic [15:0] dec_out_smp_o;
    logic [15:0] ev;
    logic dhome;
    shc_pkg::shc_status_t status_o;
    int n_mismatch = 0, checked = 0, seed = 10164, cyc = 0, n_early = 0;
    shc_homing_ctrl u_shc_homing_ctrl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i),
        .pat_wr_i(pat_wr_i), .enc_smp_valid_i(enc_smp_valid_i), .enc_smp_i(enc_smp_i),
        .enc_frame_done_i(enc_frame_done_i), .dec_bit_valid_i(dec_bit_valid_i), .dec_bit_i(dec_bit_i),
        .dec_smp_valid_i(dec_smp_valid_i), .dec_smp_i(dec_smp_i), .dec_out_valid_o(dec_out_valid_o),
        .dec_out_smp_o(dec_out_smp_o), .enc_home_reset_o(enc_home_reset_o),
        .dec_home_reset_o(dec_home_reset_o), .dec_early_hit_o(dec_early_hit_o), .status_o(status_o));
    shc_remote_codec u_shc_remote_codec (.core_clk_i(core_clk_i), .dec_bit_valid_o(dec_bit_valid_i),
        .dec_bit_o(dec_bit_i));
    initial forever #12.5 core_clk_i = ~core_clk_i;
    // Early hits are counted; the run is cut short if it hangs
    always @(posedge core_clk_i) begin
        cyc++;
        if (dec_early_hit_o === 1'b1) n_early++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task tick;
        @(posedge core_clk_i);
        #1;
    endtask : tick
    task chk(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk
    task chks(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t sample %h expected %h", $time, got, exp);
        end
    endtask : chks
    // Expected decoder output: the homing sample replaces speech only for a frame that began in home state
    function automatic logic [15:0] exp_out(input logic sub, input logic [15:0] s);
        return sub ? 16'h0008 : s;
    endfunction : exp_out
    // Prints the counts, then the verdict, and ends the run
    task close_out;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    // Mode is fixed while reset is held
    task do_reset(input logic [2:0] m);
        rst_n_i = 1'b0;
        cfg_i = '{m, 8'h10, 8'h06};
        repeat (2) tick();
        rst_n_i = 1'b1;
        dhome = 1'b1;
    endtask : do_reset
    // Parameter frame, then its 160-sample output frame
    task dec_frame(input logic hom, input logic [2:0] m);
        logic h;
        h = hom && (m == cfg_i.mode);
        n_early = 0;
        u_shc_remote_codec.send(hom, m, cfg_i.mode);
        repeat (2) tick();
        chk(status_o.dec_homing, h);
        chk(n_early == (h && dhome), 1'b1);
        for (int k = 0; k <= 160; k++) begin
            tick();
            if (k > 0) chks(dec_out_smp_o, ev);
            if (k > 0) chk(dec_out_valid_o, 1'b1);
            dec_smp_i = 16'($random(seed));
            dec_smp_valid_i = (k < 160);
            ev = exp_out(h && dhome, dec_smp_i);
        end
        chk(dec_home_reset_o, h);
        repeat (2) tick();
        chk(status_o.dec_in_home, h);
        chk(dec_out_valid_o, 1'b0);
        dhome = h;
    endtask : dec_frame
    // Encoder input run: n samples of v, or random ones that can never be homing samples
    task enc_send(input int n, input logic rnd, input logic [15:0] v);
        for (int k = 0; k < n; k++) begin
            tick();
            enc_smp_valid_i = 1'b1;
            enc_smp_i = rnd ? (16'($random(seed)) | 16'h0001) : v;
        end
        tick();
        enc_smp_valid_i = 1'b0;
    endtask : enc_send
    // Frame decision, then the core's completion strobe and the reset that follows it
    task enc_end(input logic hom, input logic exp, input logic rst);
        chk(status_o.enc_homing, hom);
        chk(status_o.enc_expect_dhf, exp);
        enc_frame_done_i = 1'b1;
        tick();
        enc_frame_done_i = 1'b0;
        chk(enc_home_reset_o, rst);
        chk(status_o.enc_in_home, rst);
    endtask : enc_end
    initial begin
        repeat (2) tick();
        rst_n_i = 1'b1;
        // Load every mode's pattern
        for (int a = 0; a < 128; a++) begin
            pat_wr_i = '{1'b1, {a[6:4], 4'h0, a[3:0]}, u_shc_remote_codec.pb(a[6:4], a[3:0])};
            tick();
        end
        pat_wr_i = '0;
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            dec_frame(1'b1, 3'(m));
            dec_frame(1'b1, 3'(m + 1));
            dec_frame(1'b1, 3'(m));
            dec_frame(1'b0, 3'(m));
        end
        do_reset(3'h0);
        enc_send(160, 1'b0, 16'h0008);
        enc_end(1'b1, 1'b1, 1'b1);
        enc_send(159, 1'b0, 16'h0008);
        enc_send(1, 1'b0, 16'h0009);
        enc_end(1'b0, 1'b0, 1'b0);
        enc_send(160, 1'b0, 16'h0008);
        enc_end(1'b1, 1'b0, 1'b1);
        enc_send(1, 1'b1, 16'h0000);
        enc_send(159, 1'b0, 16'h0008);
        enc_end(1'b0, 1'b0, 1'b0);
        enc_send(1, 1'b0, 16'h0008);
        enc_send(159, 1'b1, 16'h0000);
        enc_end(1'b0, 1'b0, 1'b0);
        close_out();
    end
endmodule : speech_codec_homing_control_tb
`default_nettype wire
